/* include/asf_pkg.sv */
// Shared constants and types for the acquisition sample capture link
`default_nettype none
package asf_pkg;
   // ****************************************
   // Widths and sizes
   // ****************************************
   localparam int SAMPLE_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_N = 2;
   localparam int FIFO_SAMPLE = 0;
   localparam int FIFO_AUX = 1;
   localparam int SWITCH_W = 8;
   localparam int SEL_W = 4;
   localparam int AV_ADDR_W = SWITCH_W + SEL_W;
   localparam int AV_DATA_W = 32;

   // ****************************************
   // Register offsets within the board window
   // ****************************************
   localparam logic [3:0] OFS_SAMPLE = 4'h0;
   localparam logic [3:0] OFS_AUX = 4'h1;
   localparam logic [3:0] OFS_FLAGS = 4'h2;
   localparam logic [3:0] OFS_STATUS = 4'h3;
   localparam logic [3:0] OFS_MASK = 4'h4;
   localparam logic [3:0] OFS_COUNTER = 4'h5;
   localparam logic [3:0] OFS_STRAPS = 4'h6;
   localparam int FLASH_BIT = 3;
   localparam int FLASH_IDX_W = 3;
   localparam int FLASH_WORDS = 8;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int FLAG_EMPTY = 0;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_FULL = 2;
   localparam int FLAG_STRIDE = 3;
   localparam int AUX_SCAN_STATE = 0;
   localparam int AUX_SENSOR = 1;
   localparam int AUX_CHAN = 2;
   localparam int ST_HALF = 0;
   localparam int ST_FULL = 1;
   localparam int ST_OVERFLOW = 2;
   localparam int ST_SCAN = 3;
   localparam int ST_W = 4;
   localparam logic [ST_W-1:0] ST_RESET = 4'h0;

   // ****************************************
   // Counters
   // ****************************************
   localparam int CNT_N = 3;
   localparam int CNT_W = 16;
   localparam int CNT_SAMPLE = 0;
   localparam int CNT_TICK = 1;
   localparam int CNT_SCAN = 2;

   // ****************************************
   // Acquisition end
   // ****************************************
   localparam int CONV_CNT_W = 3;
   localparam logic [CONV_CNT_W-1:0] CONV_CYCLES = 3'h4;

   typedef enum logic [1:0] {
      ACQ_IDLE = 2'b01,
      ACQ_CONV = 2'b10
   } asf_acq_state_t;
endpackage : asf_pkg
`default_nettype wire

/* include/asf_link_if.sv */
// Ribbon link between the acquisition board and the capture port
`default_nettype none
interface asf_link_if;
   logic busy;
   logic [asf_pkg::SAMPLE_W-1:0] data;
   logic chan_sel;
   logic scan_start_sensor;
   logic scan_state;

   modport dev (
      input busy,
      input data,
      input chan_sel,
      input scan_start_sensor,
      input scan_state
   );

   modport acq (
      output busy,
      output data,
      output chan_sel,
      output scan_start_sensor,
      output scan_state
   );
endinterface : asf_link_if
`default_nettype wire

/* hdl/asf_acq_end.sv */
// Acquisition board end of the ribbon link
`default_nettype none
module asf_acq_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Ribbon link
   asf_link_if.acq link,
   // Converter side
   input wire logic conv_start,
   input wire logic [asf_pkg::SAMPLE_W-1:0] conv_sample,
   input wire logic conv_chan_two,
   output logic conv_ready,
   // Scan state
   input wire logic in_scan,
   input wire logic acquiring
);
   asf_pkg::asf_acq_state_t state_q;
   logic [asf_pkg::CONV_CNT_W-1:0] cnt_q;
   logic busy_q;
   logic chan_q;
   logic sensor_q;
   logic scan_q;
   logic [asf_pkg::SAMPLE_W-1:0] data_q;

   // ****************************************
   // Conversion sequencer
   // ****************************************
   // Data and channel stay put after busy falls, so the far end can take them late
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= asf_pkg::ACQ_IDLE;
         cnt_q <= '0;
         busy_q <= 1'b0;
         chan_q <= 1'b0;
         data_q <= '0;
      end else begin
         case (state_q)
            asf_pkg::ACQ_IDLE: begin
               if (conv_start) begin
                  data_q <= conv_sample;
                  chan_q <= conv_chan_two; // RULE3
                  busy_q <= 1'b1; // RULE2
                  cnt_q <= asf_pkg::CONV_CYCLES - 3'h1;
                  state_q <= asf_pkg::ACQ_CONV;
               end
            end
            asf_pkg::ACQ_CONV: begin
               if (cnt_q == '0) begin
                  busy_q <= 1'b0; // RULE2
                  state_q <= asf_pkg::ACQ_IDLE;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            default: begin
               busy_q <= 1'b0;
               state_q <= asf_pkg::ACQ_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Scan state lines
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sensor_q <= 1'b1;
         scan_q <= 1'b0;
      end else begin
         sensor_q <= ~in_scan; // RULE5
         scan_q <= acquiring; // RULE6
      end
   end

   assign conv_ready = (state_q == asf_pkg::ACQ_IDLE);
   assign link.busy = busy_q;
   assign link.data = data_q;
   assign link.chan_sel = chan_q;
   assign link.scan_start_sensor = sensor_q;
   assign link.scan_state = scan_q;
endmodule : asf_acq_end
`default_nettype wire

/* hdl/asf_capture_port.sv */
// Host capture port: sample FIFOs, flags, counters and host register window
//
// Operation
// RULE1: Buffer acquisition samples until host reads them
// RULE2: Write strobe comes from converter busy
// RULE3: Channel select low ch1, high ch2
// RULE4: Each FIFO shows empty, half, full
// RULE5: Sensor line low scanning, high turnaround
// RULE6: Scan state high acquiring, low turnaround
// RULE7: Jumpers pick counter 0 or 2 output
// RULE8: Flash jumper blocks all flash access
// RULE9: Host address decoded from address switch
// RULE10: Interrupt follows sample FIFO half-full level
`default_nettype none
module asf_capture_port #(
   parameter int DEPTH = asf_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Ribbon link
   asf_link_if.dev link,
   // Host bus
   input wire logic [asf_pkg::AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [asf_pkg::AV_DATA_W-1:0] avs_writedata,
   output logic [asf_pkg::AV_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Board straps
   input wire logic [asf_pkg::SWITCH_W-1:0] io_address_switch,
   input wire logic flash_disable_jumper,
   input wire logic counter_zero_select_jumper,
   input wire logic counter_two_select_jumper,
   input wire logic counter_select_link,
   // Status outputs
   output logic irq,
   output logic fifo_irq,
   output logic counter_out,
   output logic [asf_pkg::FIFO_N*asf_pkg::FLAG_STRIDE-1:0] flag_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] HALF_LEVEL = (AW+1)'(DEPTH / 2);
   localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

   logic busy_q;
   logic wr_stb;
   logic [asf_pkg::FIFO_N-1:0] push;
   logic [asf_pkg::FIFO_N-1:0] pop;
   logic [asf_pkg::FIFO_N-1:0] empty;
   logic [asf_pkg::FIFO_N-1:0] half;
   logic [asf_pkg::FIFO_N-1:0] full;
   logic [asf_pkg::FIFO_N-1:0] rd_valid_q;
   logic [asf_pkg::SAMPLE_W-1:0] word_in [asf_pkg::FIFO_N];
   logic [asf_pkg::SAMPLE_W-1:0] head [asf_pkg::FIFO_N];
   logic [asf_pkg::SAMPLE_W-1:0] flash_q [asf_pkg::FLASH_WORDS];
   logic [asf_pkg::CNT_W-1:0] cnt_q [asf_pkg::CNT_N];
   logic [asf_pkg::CNT_N-1:0] cnt_evt;
   logic [1:0] cnt_sel;
   logic ack_q;
   logic req;
   logic acc;
   logic hit;
   logic flash_sel;
   logic flash_ok;
   logic [asf_pkg::SEL_W-1:0] ofs;
   logic [asf_pkg::AV_DATA_W-1:0] rd_mux;
   logic [asf_pkg::AV_DATA_W-1:0] rdata_q;
   logic [asf_pkg::ST_W-1:0] status_q;
   logic [asf_pkg::ST_W-1:0] mask_q;
   logic [asf_pkg::ST_W-1:0] st_evt;
   logic [asf_pkg::ST_W-1:0] st_clr;
   logic half_q;
   logic full_q;
   logic sensor_q;
   logic counter_out_q;

   // ****************************************
   // Link capture
   // ****************************************
   // The link is synchronous, so busy falling marks a finished conversion
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         sensor_q <= 1'b1;
      end else begin
         busy_q <= link.busy;
         sensor_q <= link.scan_start_sensor;
      end
   end

   assign wr_stb = busy_q & ~link.busy; // RULE2

   always_comb begin
      word_in[asf_pkg::FIFO_SAMPLE] = link.data;
      word_in[asf_pkg::FIFO_AUX] = '0;
      word_in[asf_pkg::FIFO_AUX][asf_pkg::AUX_SCAN_STATE] = link.scan_state;
      word_in[asf_pkg::FIFO_AUX][asf_pkg::AUX_SENSOR] = link.scan_start_sensor;
      word_in[asf_pkg::FIFO_AUX][asf_pkg::AUX_CHAN] = link.chan_sel;
   end

   // ****************************************
   // Sample and auxiliary FIFOs
   // ****************************************
   // A strobe into a full FIFO is dropped and flagged, never overwrites the oldest word
   for (genvar f = 0; f < asf_pkg::FIFO_N; f++) begin : g_fifo
      logic [asf_pkg::SAMPLE_W-1:0] mem_q [DEPTH];
      logic [AW-1:0] wr_ptr_q;
      logic [AW-1:0] rd_ptr_q;
      logic [AW:0] count_q;

      assign push[f] = wr_stb & ~full[f]; // RULE1
      assign pop[f] = acc & avs_read & hit & ~flash_sel & (ofs == (asf_pkg::SEL_W)'(f)) & rd_valid_q[f];
      assign empty[f] = (count_q == '0); // RULE4
      assign half[f] = (count_q >= HALF_LEVEL); // RULE4
      assign full[f] = (count_q == FULL_LEVEL); // RULE4
      assign head[f] = empty[f] ? '0 : mem_q[rd_ptr_q];
      assign flag_out[f*asf_pkg::FLAG_STRIDE+asf_pkg::FLAG_EMPTY] = empty[f];
      assign flag_out[f*asf_pkg::FLAG_STRIDE+asf_pkg::FLAG_HALF] = half[f];
      assign flag_out[f*asf_pkg::FLAG_STRIDE+asf_pkg::FLAG_FULL] = full[f];

      always_ff @(posedge clk) begin
         if (push[f]) begin
            mem_q[wr_ptr_q] <= word_in[f]; // RULE1
         end
      end

      always_ff @(posedge clk) begin
         if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
         end else begin
            if (push[f]) begin
               wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop[f]) begin
               rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            case ({push[f], pop[f]})
               2'b10: count_q <= count_q + 1'b1;
               2'b01: count_q <= count_q - 1'b1;
               default: count_q <= count_q;
            endcase
         end
      end
   end

   assign fifo_irq = half[asf_pkg::FIFO_SAMPLE]; // RULE10

   // ****************************************
   // Counters
   // ****************************************
   assign cnt_evt[asf_pkg::CNT_SAMPLE] = push[asf_pkg::FIFO_SAMPLE];
   assign cnt_evt[asf_pkg::CNT_TICK] = 1'b1;
   assign cnt_evt[asf_pkg::CNT_SCAN] = sensor_q & ~link.scan_start_sensor;

   for (genvar c = 0; c < asf_pkg::CNT_N; c++) begin : g_cnt
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            cnt_q[c] <= '0;
         end else if (cnt_evt[c]) begin
            cnt_q[c] <= cnt_q[c] + 1'b1;
         end
      end
   end

   // The fitted link overrides both jumpers and routes the free-running counter
   always_comb begin
      if (counter_select_link) begin
         cnt_sel = 2'(asf_pkg::CNT_TICK);
      end else if (counter_zero_select_jumper) begin
         cnt_sel = 2'(asf_pkg::CNT_SAMPLE); // RULE7
      end else if (counter_two_select_jumper) begin
         cnt_sel = 2'(asf_pkg::CNT_SCAN); // RULE7
      end else begin
         cnt_sel = 2'(asf_pkg::CNT_TICK);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         counter_out_q <= 1'b0;
      end else begin
         counter_out_q <= cnt_q[cnt_sel][asf_pkg::CNT_W-1]; // RULE7
      end
   end

   assign counter_out = counter_out_q;

   // ****************************************
   // Host bus slave
   // ****************************************
   // One wait state on every access; a miss still answers so the master never hangs
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign acc = req & ack_q;
   assign hit = (avs_address[asf_pkg::AV_ADDR_W-1:asf_pkg::SEL_W] == io_address_switch); // RULE9
   assign ofs = avs_address[asf_pkg::SEL_W-1:0];
   assign flash_sel = ofs[asf_pkg::FLASH_BIT];
   assign flash_ok = hit & flash_sel & ~flash_disable_jumper; // RULE8

   always_comb begin
      rd_mux = '0;
      if (flash_ok) begin
         rd_mux[asf_pkg::SAMPLE_W-1:0] = flash_q[ofs[asf_pkg::FLASH_IDX_W-1:0]];
      end else if (hit && !flash_sel) begin
         case (ofs)
            asf_pkg::OFS_SAMPLE: rd_mux[asf_pkg::SAMPLE_W-1:0] = head[asf_pkg::FIFO_SAMPLE];
            asf_pkg::OFS_AUX: rd_mux[asf_pkg::SAMPLE_W-1:0] = head[asf_pkg::FIFO_AUX];
            asf_pkg::OFS_FLAGS: rd_mux[asf_pkg::FIFO_N*asf_pkg::FLAG_STRIDE-1:0] = flag_out;
            asf_pkg::OFS_STATUS: rd_mux[asf_pkg::ST_W-1:0] = status_q;
            asf_pkg::OFS_MASK: rd_mux[asf_pkg::ST_W-1:0] = mask_q;
            asf_pkg::OFS_COUNTER: rd_mux[asf_pkg::CNT_W-1:0] = cnt_q[cnt_sel];
            asf_pkg::OFS_STRAPS: rd_mux[asf_pkg::SWITCH_W+3:0] = {flash_disable_jumper, counter_select_link,
               counter_two_select_jumper, counter_zero_select_jumper, io_address_switch};
            default: rd_mux = '0;
         endcase
      end
   end

   // Read data is frozen at the first cycle so a late push cannot slip past the pop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
         rd_valid_q <= '0;
      end else begin
         ack_q <= req & ~ack_q;
         if (req && !ack_q) begin
            rdata_q <= rd_mux;
            rd_valid_q <= ~empty;
         end
      end
   end

   assign avs_readdata = rdata_q;

   always_ff @(posedge clk) begin
      if (acc && avs_write && flash_ok) begin
         flash_q[ofs[asf_pkg::FLASH_IDX_W-1:0]] <= avs_writedata[asf_pkg::SAMPLE_W-1:0]; // RULE8
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   assign st_evt[asf_pkg::ST_HALF] = half[asf_pkg::FIFO_SAMPLE] & ~half_q;
   assign st_evt[asf_pkg::ST_FULL] = full[asf_pkg::FIFO_SAMPLE] & ~full_q;
   assign st_evt[asf_pkg::ST_OVERFLOW] = wr_stb & (|full);
   assign st_evt[asf_pkg::ST_SCAN] = cnt_evt[asf_pkg::CNT_SCAN];
   assign st_clr = (acc && avs_write && hit && !flash_sel && ofs == asf_pkg::OFS_STATUS) ?
      avs_writedata[asf_pkg::ST_W-1:0] : '0;

   // A new event in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q <= asf_pkg::ST_RESET;
         half_q <= 1'b0;
         full_q <= 1'b0;
      end else begin
         status_q <= (status_q & ~st_clr) | st_evt;
         half_q <= half[asf_pkg::FIFO_SAMPLE];
         full_q <= full[asf_pkg::FIFO_SAMPLE];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_q <= asf_pkg::ST_RESET;
      end else if (acc && avs_write && hit && !flash_sel && ofs == asf_pkg::OFS_MASK) begin
         mask_q <= avs_writedata[asf_pkg::ST_W-1:0];
      end
   end

   assign irq = |(status_q & mask_q);
endmodule : asf_capture_port
`default_nettype wire

/* bench/asf_link_properties.sv */
// Checker for the ribbon link between the acquisition end and the capture port
`default_nettype none
module asf_link_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Ribbon link
   input wire logic busy,
   input wire logic [asf_pkg::SAMPLE_W-1:0] data,
   input wire logic chan_sel,
   input wire logic scan_start_sensor,
   input wire logic scan_state,
   // Acquisition side
   input wire logic conv_start,
   input wire logic [asf_pkg::SAMPLE_W-1:0] conv_sample,
   input wire logic conv_chan_two,
   input wire logic conv_ready,
   input wire logic in_scan,
   input wire logic acquiring
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ****************************************
   // Conversion sequences
   // ****************************************
   sequence s_take;
      conv_start && conv_ready;
   endsequence
   sequence s_conv;
      busy [*4] ##1 !busy;
   endsequence

   // ****************************************
   // Properties
   // ****************************************
   property p_busy_len;
      $rose(busy) |-> s_conv;
   endproperty
   property p_take_busy;
      s_take |=> s_conv;
   endproperty
   property p_take_data;
      s_take |=> data == $past(conv_sample);
   endproperty
   property p_take_chan;
      s_take |=> chan_sel == $past(conv_chan_two);
   endproperty
   // Past guard keeps values from before a reset out of the comparison
   property p_data_hold;
      $past(rst_n) && !$rose(busy) |-> $stable(data) && $stable(chan_sel);
   endproperty
   property p_ready;
      conv_ready == !busy;
   endproperty
   property p_sensor;
      $past(rst_n) |-> scan_start_sensor == !$past(in_scan);
   endproperty
   property p_state;
      $past(rst_n) |-> scan_state == $past(acquiring);
   endproperty

   a_busy_len: assert property (p_busy_len) else $error("busy width wrong");
   a_take_busy: assert property (p_take_busy) else $error("start gave no busy pulse");
   a_take_data: assert property (p_take_data) else $error("sample not launched");
   a_take_chan: assert property (p_take_chan) else $error("channel select wrong");
   a_data_hold: assert property (p_data_hold) else $error("sample moved between starts");
   a_ready: assert property (p_ready) else $error("ready not idle");
   a_sensor: assert property (p_sensor) else $error("sensor level wrong");
   a_state: assert property (p_state) else $error("scan state level wrong");
endmodule : asf_link_properties
`default_nettype wire

/* bench/acquisition_sample_fifo_port_tb.sv */
// Testbench joining both link ends and driving the host bus
`default_nettype none
module acquisition_sample_fifo_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = 4;
   logic clk, rst_n, conv_start, conv_chan_two, conv_ready, in_scan, acquiring;
   logic [15:0] conv_sample, s, d;
   logic [11:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, irq, fifo_irq, counter_out, ch, a;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0] io_address_switch;
   logic flash_disable_jumper, counter_zero_select_jumper, counter_two_select_jumper, counter_select_link;
   logic [5:0] flag_out;
   logic [15:0] exp_q[$];
   logic [2:0] aux_q[$];
   int err_count, checks_done;
   int ticks = 0;

   asf_link_if link();
   asf_acq_end u_asf_acq_end (.clk(clk), .rst_n(rst_n), .link(link), .conv_start(conv_start),
      .conv_sample(conv_sample), .conv_chan_two(conv_chan_two), .conv_ready(conv_ready),
      .in_scan(in_scan), .acquiring(acquiring));
   asf_capture_port #(.DEPTH(DEPTH)) u_asf_capture_port (.clk(clk), .rst_n(rst_n), .link(link),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .io_address_switch(io_address_switch),
      .flash_disable_jumper(flash_disable_jumper), .counter_zero_select_jumper(counter_zero_select_jumper),
      .counter_two_select_jumper(counter_two_select_jumper), .counter_select_link(counter_select_link),
      .irq(irq), .fifo_irq(fifo_irq), .counter_out(counter_out), .flag_out(flag_out));
   asf_link_properties u_asf_link_properties (.clk(clk), .rst_n(rst_n), .busy(link.busy), .data(link.data),
      .chan_sel(link.chan_sel), .scan_start_sensor(link.scan_start_sensor), .scan_state(link.scan_state),
      .conv_start(conv_start), .conv_sample(conv_sample), .conv_chan_two(conv_chan_two),
      .conv_ready(conv_ready), .in_scan(in_scan), .acquiring(acquiring));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [5:0] fl(input int c);
      return {2{c == DEPTH, c >= DEPTH / 2, c == 0}};
   endfunction : fl
   function automatic logic [11:0] ad(input logic [3:0] ofs);
      return {io_address_switch, ofs};
   endfunction : ad
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Waitrequest is sampled at the rising edge; the write lands and read data is taken at that same edge
   task automatic acc(input logic wr, input logic [11:0] adr, input logic [31:0] wd, output logic [31:0] rv);
      int n;
      n = 0;
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= adr;
      avs_writedata <= wd;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge clk);
      end
      rv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk("answer", 0, n == 50);
   endtask : acc
   // Start, four busy cycles, strobe, push, then flags settle
   task automatic conv(input logic [15:0] smp, input logic c2, input logic acq);
      @(posedge clk);
      conv_sample <= smp;
      conv_chan_two <= c2;
      acquiring <= acq;
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask : conv
   task automatic close_out;
      $display("Checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Mirrors the free-running tick counter for the link-fitted route
   always @(posedge clk) begin
      if (rst_n) begin
         ticks <= ticks + 1;
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {rst_n, conv_start, conv_chan_two, in_scan, acquiring, avs_read, avs_write} = '0;
      {conv_sample, avs_address, avs_writedata, err_count, checks_done} = '0;
      {flash_disable_jumper, counter_zero_select_jumper, counter_two_select_jumper, counter_select_link} = '0;
      io_address_switch = 8'hd7;
      void'($urandom(32'h02a2));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("reset", 10'h092, {flag_out, irq, fifo_irq, link.scan_start_sensor, link.scan_state});
      $display("Test reset done");
      for (int u = 0; u < 2; u++) begin
         @(posedge clk);
         io_address_switch <= u ? 8'h57 : 8'hd7;
         @(negedge clk);
         acc(0, ad(asf_pkg::OFS_STRAPS), 0, rd);
         chk("straps", {24'h0, io_address_switch}, rd);
         acc(1, ad(asf_pkg::OFS_MASK) ^ 12'h800, 32'hf, rd);
         acc(0, ad(asf_pkg::OFS_MASK), 0, rd);
         chk("mask", 0, rd);
         acc(0, ad(asf_pkg::OFS_STRAPS) ^ 12'h800, 0, rd);
         chk("miss", 0, rd);
      end
      $display("Test address done");
      for (int i = 0; i <= DEPTH; i++) begin
         s = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
         ch = 1'($urandom);
         a = 1'($urandom);
         conv(s, ch, a);
         if (i < DEPTH) begin
            exp_q.push_back(s);
            aux_q.push_back({ch, 1'b1, a});
         end
         chk("flags", fl(exp_q.size()), flag_out);
         chk("fifo_irq", exp_q.size() >= DEPTH / 2, fifo_irq);
      end
      acc(0, ad(asf_pkg::OFS_STATUS), 0, rd);
      chk("status", 32'h7, rd);
      chk("irq masked", 0, irq);
      acc(1, ad(asf_pkg::OFS_MASK), 32'h4, rd);
      @(negedge clk);
      chk("irq", 1, irq);
      acc(1, ad(asf_pkg::OFS_STATUS), 32'h4, rd);
      @(negedge clk);
      chk("irq clear", 0, irq);
      for (int i = 0; i < DEPTH; i++) begin
         acc(0, ad(asf_pkg::OFS_SAMPLE), 0, rd);
         chk("sample", {16'h0, exp_q[i]}, rd);
         acc(0, ad(asf_pkg::OFS_AUX), 0, rd);
         chk("aux", {29'h0, aux_q[i]}, rd);
      end
      acc(0, ad(asf_pkg::OFS_SAMPLE), 0, rd);
      chk("empty pop", 0, rd);
      @(negedge clk);
      chk("flags empty", fl(0), flag_out);
      $display("Test fifo done");
      @(posedge clk);
      in_scan <= 1'b1;
      repeat (3) @(negedge clk);
      chk("sensor", 0, link.scan_start_sensor);
      acc(0, ad(asf_pkg::OFS_STATUS), 0, rd);
      chk("scan status", 32'hb, rd);
      counter_zero_select_jumper <= 1'b1;
      acc(0, ad(asf_pkg::OFS_COUNTER), 0, rd);
      chk("counter0", DEPTH, rd);
      counter_zero_select_jumper <= 1'b0;
      counter_two_select_jumper <= 1'b1;
      acc(0, ad(asf_pkg::OFS_COUNTER), 0, rd);
      chk("counter2", 1, rd);
      chk("counter out", 0, counter_out);
      counter_select_link <= 1'b1;
      acc(0, ad(asf_pkg::OFS_COUNTER), 0, rd);
      chk("counter link", {16'h0, 16'(ticks - 1)}, rd);
      counter_select_link <= 1'b0;
      $display("Test counter done");
      d = 16'($urandom);
      acc(1, ad(4'h9), {16'h0, d}, rd);
      acc(0, ad(4'h9), 0, rd);
      chk("flash", {16'h0, d}, rd);
      flash_disable_jumper <= 1'b1;
      acc(1, ad(4'h9), {16'h0, ~d}, rd);
      acc(0, ad(4'h9), 0, rd);
      chk("flash blocked", 0, rd);
      flash_disable_jumper <= 1'b0;
      acc(0, ad(4'h9), 0, rd);
      chk("flash kept", {16'h0, d}, rd);
      $display("Test flash done");
      close_out();
   end
endmodule : acquisition_sample_fifo_port_tb
`default_nettype wire
